// File: src/usb_event_status.sv
`timescale 1ns/1ps
module usb_event_status #(
  parameter int PSEUDO_FRAME_START_FLAG_CYCLES = usb_event_pkg::FRAME_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [usb_event_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire usb_event_pkg::usb_events_type events_i,
  output usb_event_pkg::reset_req_type       reset_req_o,
  output logic                               external_reset_o,
  output logic                               usb_irq_o,
  output logic                               function_enable_o,
  output logic                               bus_connect_o,
  output logic                               remote_wakeup_o
);
  import usb_event_pkg::*;

  // Bus slave state
  // Single-cycle slave: ack, then one idle cycle
  logic        ack_reg;        // Acknowledge
  logic        ack_next;
  logic [31:0] rdata_reg;      // Read data
  logic [31:0] rdata_next;

  // Software registers
  // Only the low byte of each word is backed by flops
  logic [7:0]  mask_reg;       // Interrupt mask
  logic [7:0]  mask_next;
  logic [7:0]  control_reg;    // USB control
  logic [7:0]  control_next;

  // Outputs held in flops
  // Registered so no output glitches on a decode
  logic        irq_reg;
  logic        irq_next;
  logic        engine_rst_reg;
  logic        engine_rst_next;
  logic        system_rst_reg;
  logic        system_rst_next;

  // Pseudo frame timer
  // Counter wide enough for a full period at 40 MHz
  logic [FRAME_CNT_W-1:0] frame_cnt_reg;
  logic [FRAME_CNT_W-1:0] frame_cnt_next;
  logic                   pseudo_frame_start_flag_reg;   // One-cycle pseudo start
  logic                   pseudo_frame_start_flag_next;

  // Decoded bus terms
  // Combinational terms, rebuilt every cycle
  logic        req;            // Request present
  logic        commit;         // Edge at which master sees ack
  logic        wr_lane0;       // Low byte written
  logic [15:0] index;          // Word index
  logic        vector_wr;      // Clearing write
  logic [7:0]  set_vec;        // Event set strobes
  logic [7:0]  status;         // Flag image
  logic        ext_en;         // Reset extension enabled
  logic        bus_rst;        // Host reset level

  // Last count of one pseudo frame period
  localparam logic [FRAME_CNT_W-1:0] PSEUDO_FRAME_START_FLAG_LAST =
    FRAME_CNT_W'(PSEUDO_FRAME_START_FLAG_CYCLES - 1);

  // Address decode and write commit
  // Writes land on the edge where the master samples ack high,
  // so a master that holds its request past ack writes again at the next ack
  always_comb begin
    // Request seen while cycle and strobe both stand
    req       = wb_cyc_i && wb_stb_i;
    // Commit only while ack stands for this request
    commit    = req && ack_reg;
    // Only the low byte lane carries register data
    wr_lane0  = commit && wb_we_i && wb_sel_i[0];
    index     = wb_adr_i[ADR_W-1:2];
    // Any low byte write to the vector index clears flags
    vector_wr = wr_lane0 && (index == VECTOR_IDX);
    // Extension enable read straight from control
    ext_en    = control_reg[RST_EXT_BIT];
    // Host reset arrives as a level
    bus_rst   = events_i.bus_reset;
  end

  // Event set strobes per status bit
  // A level held on an input sets its flag again each cycle
  always_comb begin
    set_vec                = 8'h00;
    // Bit 1 keeps its zero strobe
    // bus reset flag
    set_vec[BUS_RESET_BIT] = bus_rst;
    set_vec[SUSPEND_BIT]   = events_i.suspend;
    set_vec[RESUME_BIT]    = events_i.resume;
    set_vec[SOF_BIT]       = events_i.sof;
    set_vec[PSEUDO_FRAME_START_FLAG_BIT]      = pseudo_frame_start_flag_reg;
    set_vec[SETUP_BIT]     = events_i.setup_done;
    set_vec[OVERWRITE_BIT] = events_i.setup_overwrite;
  end

  // Sticky flags, one cell per used bit
  // Bit 1 has no cell, so it can never read back as one
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_flag
      if (i == RESERVED_BIT) begin : g_rsv
        assign status[i] = 1'b0;
      end else begin : g_cell
        event_flag_cell #(
          .RESET_VAL (STATUS_RST[i])
        ) u_cell (
          .clk_i   (clk_i),
          .srst_i  (srst_i),
          .set_i   (set_vec[i]),
          .clear_i (vector_wr),
          .flag_o  (status[i])
        );
      end
    end
  endgenerate

  // Pseudo frame timer next state
  // Counts clocks since the last host start, bus reset or wrap;
  // a host start restarts the count, so pseudo starts never
  // crowd a real one
  always_comb begin
    frame_cnt_next = frame_cnt_reg;
    pseudo_frame_start_flag_next      = 1'b0;
    if (bus_rst || events_i.sof) begin
      frame_cnt_next = '0;
    end else if (frame_cnt_reg == PSEUDO_FRAME_START_FLAG_LAST) begin
      // one period elapsed
      // Wrap restarts the period
      frame_cnt_next = '0;
      pseudo_frame_start_flag_next      = !events_i.frame_locked;
    end else begin
      // Still inside the current frame
      frame_cnt_next = frame_cnt_reg + 1'b1;
    end
  end

  // Pseudo frame timer registers
  // Strobe is registered, so bit 3 sets one cycle after the wrap edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      frame_cnt_reg <= '0;
      pseudo_frame_start_flag_reg      <= 1'b0;
    end else begin
      frame_cnt_reg <= frame_cnt_next;
      pseudo_frame_start_flag_reg      <= pseudo_frame_start_flag_next;
    end
  end

  // Mask and control next values
  always_comb begin
    mask_next    = mask_reg;
    control_next = control_reg;
    if (wr_lane0 && index == MASK_IDX) begin
      mask_next = wb_dat_i[7:0];
      // Reserved mask bit never stores a one
      mask_next[RESERVED_BIT] = 1'b0;
    end
    // Control keeps bits 7:4 only; the low nibble reads zero
    if (wr_lane0 && index == CONTROL_IDX) begin
      control_next = wb_dat_i[7:0] & CONTROL_WMASK;
    end
    // Host reset outranks a software write in the same cycle
    if (bus_rst) begin
      control_next[FUNC_EN_BIT] = 1'b0;
      if (ext_en) begin
        mask_next                = MASK_RST;
        // Wakeup request drops with the mask; connect and extension bits keep their values
        control_next[WAKEUP_BIT] = 1'b0;
      end
      control_next[RST_EXT_BIT] = control_reg[RST_EXT_BIT];
      control_next[CONNECT_BIT] = control_reg[CONNECT_BIT];
    end
  end

  // Mask and control registers
  // Device reset clears both; host reset is handled above
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_reg    <= MASK_RST;
      control_reg <= CONTROL_RST;
    end else begin
      mask_reg    <= mask_next;
      control_reg <= control_next;
    end
  end

  // Interrupt and reset request next values
  // Flags and mask are flops, so irq trails them by a cycle
  // Engine request follows the host reset level; system request follows it only with extension enabled
  always_comb begin
    irq_next        = |(status & mask_reg);
    engine_rst_next = bus_rst;
    system_rst_next = bus_rst && ext_en;
  end

  // Interrupt and reset request registers
  // External reset mirrors the system request flop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_reg        <= 1'b0;
      engine_rst_reg <= 1'b0;
      system_rst_reg <= 1'b0;
    end else begin
      irq_reg        <= irq_next;
      engine_rst_reg <= engine_rst_next;
      system_rst_reg <= system_rst_next;
    end
  end

  // Bus answer: ack one cycle after request, then drop
  // Read data is latched at the request edge and held
  always_comb begin
    // Ack rises for a new request, falls the cycle after
    ack_next   = req && !ack_reg;
    rdata_next = rdata_reg;
    if (req && !ack_reg) begin
      case (index)
        STATUS_IDX:  rdata_next = {24'h000000, status};
        MASK_IDX:    rdata_next = {24'h000000, mask_reg};
        CONTROL_IDX: rdata_next = {24'h000000, control_reg};
        // Unmapped and write-only indices read zero
        default:     rdata_next = 32'h00000000;
      endcase
    end
  end

  // Bus answer registers
  // Read data holds until the next request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Output drive
  // External reset and the system request share the one system flop
  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = rdata_reg;
  assign usb_irq_o          = irq_reg;
  assign reset_req_o.engine = engine_rst_reg;
  assign reset_req_o.system = system_rst_reg;
  assign external_reset_o   = system_rst_reg;
  assign function_enable_o  = control_reg[FUNC_EN_BIT];
  assign bus_connect_o      = control_reg[CONNECT_BIT];
  assign remote_wakeup_o    = control_reg[WAKEUP_BIT];

endmodule // usb_event_status

// File: src/usb_event_pkg.sv
package usb_event_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] STATUS_IDX  = 16'hFFFE;
  localparam logic [15:0] MASK_IDX    = 16'hFFFD;
  localparam logic [15:0] CONTROL_IDX = 16'hFFFC;
  localparam logic [15:0] VECTOR_IDX  = 16'hFFB2;
  localparam int          ADR_W       = 18;

  // Event bit positions in status and mask
  localparam int BUS_RESET_BIT = 7;
  localparam int SUSPEND_BIT   = 6;
  localparam int RESUME_BIT    = 5;
  localparam int SOF_BIT       = 4;
  localparam int PSEUDO_FRAME_START_FLAG_BIT      = 3;
  localparam int SETUP_BIT     = 2;
  localparam int RESERVED_BIT  = 1;
  localparam int OVERWRITE_BIT = 0;

  // Control register bit positions
  localparam int CONNECT_BIT   = 7;
  localparam int FUNC_EN_BIT   = 6;
  localparam int WAKEUP_BIT    = 5;
  localparam int RST_EXT_BIT   = 4;

  // Reset values
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hF0;

  // Frame period timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int FRAME_PERIOD_NS = 1000000;
  localparam int FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FRAME_CNT_W     = 16;

  // Event strobes from the serial engine and frame logic
  typedef struct packed {
    logic bus_reset;
    logic suspend;
    logic resume;
    logic sof;
    logic frame_locked;
    logic setup_done;
    logic setup_overwrite;
  } usb_events_type;

  // Reset requests toward the rest of the device
  typedef struct packed {
    logic engine;
    logic system;
  } reset_req_type;

endpackage

// File: src/event_flag_cell.sv
`timescale 1ns/1ps
// Sticky event flag: a set in the clearing cycle wins
module event_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_reg;   // Held flag
  logic flag_next;  // Next flag value

  // Set beats clear so no event is lost
  always_comb begin
    flag_next = flag_reg;
    if (clear_i) begin
      flag_next = 1'b0;
    end
    if (set_i) begin
      flag_next = 1'b1;
    end
  end

  // Flag storage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

endmodule // event_flag_cell

// File: tb/usb_event_source.sv
`timescale 1ns/1ps
// Serial engine stand-in: one event strobe per request cycle
module usb_event_source (
  input  wire logic                   clk_i,    // Device clock
  input  wire logic                   fire_i,   // Event request
  input  wire logic [2:0]             kind_i,   // Struct bit to strobe
  input  wire logic                   locked_i, // Frame timer lock level
  output usb_event_pkg::usb_events_type events_o  // Strobes to block
);
  import usb_event_pkg::*;
  logic [6:0] pulse_reg;  // Strobe launched after an edge
  logic [6:0] pulse_next; // Next strobe pattern
  // Decode the request into one strobe
  always_comb begin
    pulse_next = fire_i ? 7'h01 << kind_i : 7'h00;
  end
  // Register the strobe
  always_ff @(posedge clk_i) begin
    pulse_reg <= pulse_next;
  end
  // Lock is a level; strobes never land on its position
  assign events_o = usb_events_type'((pulse_reg & 7'h7B) | {4'h0, locked_i,
                                     2'h0});
endmodule // usb_event_source

// File: tb/usb_event_status_sva.sv
`timescale 1ns/1ps
// Port checks of the event status block
module usb_event_status_sva #(
  parameter int PSEUDO_FRAME_START_FLAG_CYCLES = 20 // Pseudo start period
) (
  input wire logic                          clk_i,
  input wire logic                          srst_i,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_we_i,
  input wire logic [usb_event_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                    wb_sel_i,
  input wire logic [31:0]                   wb_dat_o,
  input wire logic                          wb_ack_o,
  input wire usb_event_pkg::usb_events_type events_i,
  input wire usb_event_pkg::reset_req_type  reset_req_o,
  input wire logic                          external_reset_o,
  input wire logic                          usb_irq_o
);
  import usb_event_pkg::*;
  logic quiet; // Lock held, no flag event
  assign quiet = events_i.frame_locked &&
                 {events_i[6:3], events_i[1:0]} == 6'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Clearing write committed in a quiet stretch
  sequence clear_s;
    quiet [*2] ##1 (quiet && wb_ack_o && wb_we_i && wb_sel_i[0] &&
    wb_adr_i[17:2] == VECTOR_IDX) ##1 quiet;
  endsequence
  vector_clear_a: assert property (clear_s |=> !usb_irq_o)
    else $error("irq stays after clearing write");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reserved_zero_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[17:2] == STATUS_IDX |-> wb_dat_o[1] == 1'b0 &&
    wb_dat_o[31:8] == 24'h0) else $error("reserved status bits set");
  reset_zero_a: assert property ($fell(srst_i) |-> !usb_irq_o &&
    !external_reset_o && reset_req_o == 2'b00)
    else $error("outputs not zero after reset");
  engine_set_a: assert property (events_i.bus_reset |=>
    reset_req_o.engine) else $error("engine reset missing");
  engine_drop_a: assert property (!events_i.bus_reset |=>
    !reset_req_o.engine) else $error("engine reset without bus reset");
  system_cause_a: assert property (reset_req_o.system |->
    $past(events_i.bus_reset)) else $error("system reset without cause");
  ext_reset_match_a: assert property (external_reset_o ==
    reset_req_o.system) else $error("external reset differs");
endmodule // usb_event_status_sva
bind usb_event_status usb_event_status_sva #(.PSEUDO_FRAME_START_FLAG_CYCLES(PSEUDO_FRAME_START_FLAG_CYCLES)) chk (
  .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .events_i(events_i),
  .reset_req_o(reset_req_o), .external_reset_o(external_reset_o),
  .usb_irq_o(usb_irq_o));

// File: tb/usb_event_status_tb.sv
`timescale 1ns/1ps
module usb_event_status_tb;
  import usb_event_pkg::*;
  logic          clk_i = 0, srst_i = 1, cyc = 0, stb = 0, we = 0;
  logic          fire = 0, locked = 1, saw_ext = 0, ack, irq, ext;
  logic          fen, conn, wake;   // Control bits seen at the pins
  logic [3:0]    sel = 0, lanes = 4'hF; // Byte enables, lanes of next call
  logic [2:0]    kind = 0;
  logic [17:0]   adr = 0;
  logic [31:0]   dat = 0, rdat;
  logic [7:0]    rnd = 8'h1E;       // Random source, starts at 30
  logic [2:0]    map [7] = '{0, 2, 0, 4, 5, 6, 7}; // Struct bit to flag
  reset_req_type rreq;
  usb_events_type ev;
  logic [31:0]   exp_q [$];         // Expected read data, oldest first
  int            num_errors = 0, total_checks = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  usb_event_status #(.PSEUDO_FRAME_START_FLAG_CYCLES(20)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .events_i(ev), .reset_req_o(rreq), .external_reset_o(ext),
    .usb_irq_o(irq), .function_enable_o(fen), .bus_connect_o(conn),
    .remote_wakeup_o(wake));
  usb_event_source src (.clk_i(clk_i), .fire_i(fire), .kind_i(kind),
    .locked_i(locked), .events_o(ev));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One classic bus cycle; reads note their expected data
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    sel <= lanes;
    if (!w) exp_q.push_back({24'h0, e});
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One event strobe, then time for flag and irq
  task automatic pulse(input logic [2:0] k);
    @(posedge clk_i);
    kind <= k;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Compare read data with the oldest note
  always @(posedge clk_i) begin
    saw_ext <= saw_ext | (ext === 1'b1);
    if (ack === 1'b1 && !we) check("read", rdat, exp_q.pop_front());
  end
  // Hang guard
  always @(posedge clk_i) begin
    if (++cycles > 3000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(0, STATUS_IDX, 0, STATUS_RST);
    bus(0, 16'h0001, 0, 8'h00);
    bus(1, STATUS_IDX, 8'hFF, 0);
    bus(0, STATUS_IDX, 0, 8'h00);
    repeat (4) begin
      rnd = lfsr(rnd);
      bus(1, MASK_IDX, rnd, 0);
      bus(0, MASK_IDX, 0, rnd & 8'hFD);
    end
    // Write without the low byte lane is ignored
    lanes = 4'hE;
    bus(1, MASK_IDX, 8'h00, 0);
    bus(0, MASK_IDX, 0, rnd & 8'hFD);
    lanes = 4'hF;
    bus(1, MASK_IDX, 8'hFD, 0);
    for (int k = 0; k < 7; k++) if (k != 2) begin
      pulse(3'(k));
      check("irq", irq, 1'b1);
      bus(0, STATUS_IDX, 0, 8'h01 << map[k]);
      bus(1, VECTOR_IDX, 8'h00, 0);
      bus(0, STATUS_IDX, 0, 8'h00);
      check("irq", irq, 1'b0);
    end
    // Event strobe lands on the clearing write's commit edge
    fork
      bus(1, VECTOR_IDX, 8'h00, 0);
      begin
        @(posedge clk_i);
        kind <= 3'd3;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
      end
    join
    bus(0, STATUS_IDX, 0, 8'h10);
    bus(1, VECTOR_IDX, 8'h00, 0);
    // Unlocked timer: quiet before one period, pseudo start after
    locked <= 1'b0;
    pulse(3'd3);
    bus(1, VECTOR_IDX, 8'h00, 0);
    bus(0, STATUS_IDX, 0, 8'h00);
    repeat (20) @(posedge clk_i);
    bus(0, STATUS_IDX, 0, 8'h08);
    locked <= 1'b1;
    check("ext", saw_ext, 1'b0);
    // Bus reset with extension enabled
    bus(1, CONTROL_IDX, 8'hF0, 0);
    bus(0, CONTROL_IDX, 0, 8'hF0);
    check("fen", fen, 1'b1);
    check("wake", wake, 1'b1);
    pulse(3'd6);
    bus(0, CONTROL_IDX, 0, 8'h90);
    bus(0, MASK_IDX, 0, 8'h00);
    bus(0, STATUS_IDX, 0, 8'h88);
    check("ext", saw_ext, 1'b1);
    check("fen", fen, 1'b0);
    check("conn", conn, 1'b1);
    check("wake", wake, 1'b0);
    // Device reset in mid-run with flags and irq up
    bus(1, MASK_IDX, 8'hFF, 0);
    bus(0, MASK_IDX, 0, 8'hFD);
    check("irq", irq, 1'b1);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(0, STATUS_IDX, 0, STATUS_RST);
    bus(0, CONTROL_IDX, 0, CONTROL_RST);
    check("irq", irq, 1'b0);
    check("ext", ext, 1'b0);
    finish_test();
  end
endmodule // usb_event_status_tb
